/* File: rtl/clkbz_consts.vh */
// Addresses, field positions, reset values and timing of the clock/tone outputs
`ifndef CLKBZ_CONSTS_VH
`define CLKBZ_CONSTS_VH

`define CLKBZ_ADDR_PORT7_DIR     16'hFF27
`define CLKBZ_ADDR_OUT_CLK_SEL   16'hFF40

`define CLKBZ_PORT7_DIR_RESET    8'hFF
`define CLKBZ_OUT_CLK_SEL_RESET  8'h00
`define CLKBZ_PORT7_DIR_FIXED    8'h80

`define CLKBZ_TONE_EN_BIT        7
`define CLKBZ_TONE_SEL_HI        6
`define CLKBZ_TONE_SEL_LO        5
`define CLKBZ_DIVCLK_EN_BIT      4
`define CLKBZ_DIVCLK_SEL_HI      3
`define CLKBZ_DIVCLK_SEL_LO      0

`define CLKBZ_TONE_EXP_BASE      4'hA
`define CLKBZ_DIVCLK_SUB_CODE    4'h8
`define CLKBZ_DIVCLK_PIN         2
`define CLKBZ_TONE_PIN           3

`define CLKBZ_DIV_WIDTH          13
`define CLKBZ_PRS_HALF_DEFAULT   1

`endif

/* File: rtl/clkbz_divider.v */
// Glitch-free square-wave divider running on peripheral clock edge ticks
`timescale 1ns/1ps
`default_nettype none

module clkbz_divider #(
  parameter CW = 13
) (
  input  wire          clk_in,
  input  wire          rstn_in,
  input  wire          tick_in,
  input  wire          enable_in,
  input  wire [3:0]    exp_in,
  output reg           wave_out
);

  reg  [CW-1:0] count;
  wire [CW-1:0] one;
  wire [CW-1:0] limit;
  wire          run;

  assign one   = {{(CW-1){1'b0}}, 1'b1};
  // Half period is 2^exp peripheral edges, so the frequency is fprs/2^exp
  assign limit = (one << exp_in) - one;
  // A high phase in progress always completes before stopping
  assign run   = enable_in | wave_out;

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      count    <= {CW{1'b0}};
      wave_out <= 1'b0;
    end else if (!run) begin
      count    <= {CW{1'b0}};
      wave_out <= 1'b0;
    end else if (tick_in) begin
      if (count == limit) begin
        count    <= {CW{1'b0}};
        wave_out <= ~wave_out;
      end else begin
        count    <= count + one;
      end
    end
  end

endmodule // clkbz_divider

`default_nettype wire

/* File: rtl/clkbz_top.v */
// Clock output and tone output controller with its two control registers
`timescale 1ns/1ps
`default_nettype none
`include "clkbz_consts.vh"

module clkbz_top #(
  parameter PRS_HALF = `CLKBZ_PRS_HALF_DEFAULT
) (
  input  wire        clk_in,
  input  wire        rstn_in,
  input  wire [15:0] addr_in,
  input  wire        wr_en_in,
  input  wire        bit_wr_in,
  input  wire [2:0]  bit_sel_in,
  input  wire [7:0]  wdata_in,
  input  wire        rd_en_in,
  input  wire        sub_clk_in,
  input  wire [6:0]  port7_latch_in,
  output reg  [7:0]  rdata_out,
  output reg  [6:0]  port7_pin_out,
  output reg  [6:0]  port7_pin_oe_out
);

  reg  [7:0]  port7_direction;
  reg  [7:0]  output_clock_select;
  reg  [7:0]  next_port7_direction;
  reg  [7:0]  next_output_clock_select;
  reg  [15:0] prs_count;
  reg         prs_tick;
  reg         sub_meta;
  reg         sub_sync;
  reg         sub_run;
  reg  [6:0]  next_pin;
  reg  [7:0]  next_rdata;

  wire        tone_out_enable;
  wire        divclk_out_enable;
  wire [1:0]  tone_rate_sel;
  wire [3:0]  divclk_rate_sel;
  wire        div_path_en;
  wire        sub_path_en;
  wire [3:0]  tone_exp;
  wire        tone_wave;
  wire        div_wave;
  wire        divided_clock_pin;
  wire        tone_pin;
  wire        prs_last;

  // Byte or single-bit write merged into a register's old value
  function [7:0] merge_write;
    input [7:0] old_val;
    input       bit_mode;
    input [2:0] bit_idx;
    input [7:0] data;
    reg   [7:0] tmp;
    begin
      tmp = old_val;
      if (bit_mode)
        tmp[bit_idx] = data[0];
      else
        tmp = data;
      merge_write = tmp;
    end
  endfunction

  function hit;
    input [15:0] addr;
    input [15:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign tone_out_enable   = output_clock_select[`CLKBZ_TONE_EN_BIT];
  assign divclk_out_enable = output_clock_select[`CLKBZ_DIVCLK_EN_BIT];
  assign tone_rate_sel     =
    output_clock_select[`CLKBZ_TONE_SEL_HI:`CLKBZ_TONE_SEL_LO];
  assign divclk_rate_sel   =
    output_clock_select[`CLKBZ_DIVCLK_SEL_HI:`CLKBZ_DIVCLK_SEL_LO];

  // Codes above the subsystem code are prohibited and keep the pin low
  assign div_path_en = divclk_out_enable &
                       (divclk_rate_sel < `CLKBZ_DIVCLK_SUB_CODE);
  assign sub_path_en = divclk_out_enable &
                       (divclk_rate_sel == `CLKBZ_DIVCLK_SUB_CODE);
  // Tone exponent 10..13 from the two-bit code
  assign tone_exp    = `CLKBZ_TONE_EXP_BASE + {2'b00, tone_rate_sel};

  // Register writes
  always @* begin
    next_port7_direction     = port7_direction;
    next_output_clock_select = output_clock_select;
    if (wr_en_in && hit(addr_in, `CLKBZ_ADDR_PORT7_DIR))
      next_port7_direction = merge_write(port7_direction, bit_wr_in,
                                         bit_sel_in, wdata_in)
                             | `CLKBZ_PORT7_DIR_FIXED;
    if (wr_en_in && hit(addr_in, `CLKBZ_ADDR_OUT_CLK_SEL))
      next_output_clock_select = merge_write(output_clock_select,
                                             bit_wr_in, bit_sel_in,
                                             wdata_in);
  end

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      port7_direction     <= `CLKBZ_PORT7_DIR_RESET;
      output_clock_select <= `CLKBZ_OUT_CLK_SEL_RESET;
      rdata_out           <= 8'h00;
    end else begin
      port7_direction     <= next_port7_direction;
      output_clock_select <= next_output_clock_select;
      rdata_out           <= next_rdata;
    end
  end

  // Read data: mapped registers, zero elsewhere, held between reads
  always @* begin
    next_rdata = rdata_out;
    if (rd_en_in) begin
      if (hit(addr_in, `CLKBZ_ADDR_PORT7_DIR))
        next_rdata = port7_direction | `CLKBZ_PORT7_DIR_FIXED;
      else if (hit(addr_in, `CLKBZ_ADDR_OUT_CLK_SEL))
        next_rdata = output_clock_select;
      else
        next_rdata = 8'h00;
    end
  end

  // Peripheral clock edge ticks: one tick per fprs half period
  assign prs_last = (prs_count == PRS_HALF[15:0] - 16'h0001);
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      prs_count <= 16'h0000;
      prs_tick  <= 1'b0;
    end else if (prs_last) begin
      prs_count <= 16'h0000;
      prs_tick  <= 1'b1;
    end else begin
      prs_count <= prs_count + 16'h0001;
      prs_tick  <= 1'b0;
    end
  end

  // Subsystem clock pin synchronised, then gated on whole phases
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      sub_meta <= 1'b0;
      sub_sync <= 1'b0;
      sub_run  <= 1'b0;
    end else begin
      sub_meta <= sub_clk_in;
      sub_sync <= sub_meta;
      // Run state changes only while the synchronised clock is low
      if (!sub_sync)
        sub_run <= sub_path_en;
    end
  end

  clkbz_divider #(
    .CW (`CLKBZ_DIV_WIDTH)
  ) u_divclk (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .tick_in   (prs_tick),
    .enable_in (div_path_en),
    .exp_in    (divclk_rate_sel),
    .wave_out  (div_wave)
  );

  clkbz_divider #(
    .CW (`CLKBZ_DIV_WIDTH)
  ) u_tone (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .tick_in   (prs_tick),
    .enable_in (tone_out_enable),
    .exp_in    (tone_exp),
    .wave_out  (tone_wave)
  );

  assign divided_clock_pin = div_wave | (sub_run & sub_sync);
  assign tone_pin          = tone_wave;

  // Pin functions OR into the latch, so a zero latch passes them through
  always @* begin
    next_pin = port7_latch_in;
    next_pin[`CLKBZ_DIVCLK_PIN] = port7_latch_in[`CLKBZ_DIVCLK_PIN] |
                                  divided_clock_pin;
    next_pin[`CLKBZ_TONE_PIN]   = port7_latch_in[`CLKBZ_TONE_PIN] |
                                  tone_pin;
  end

  always @(posedge clk_in) begin
    if (!rstn_in) begin
      port7_pin_out    <= 7'h00;
      port7_pin_oe_out <= 7'h00;
    end else begin
      port7_pin_out    <= next_pin;
      port7_pin_oe_out <= ~port7_direction[6:0];
    end
  end

endmodule // clkbz_top

`default_nettype wire

/* File: tb/clkbz_properties.sv */
// Port-level properties of the clock and tone outputs
`timescale 1ns/1ps
`default_nettype none
module clkbz_properties (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [15:0] addr_in,
  input wire logic        wr_en_in,
  input wire logic        bit_wr_in,
  input wire logic [2:0]  bit_sel_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        rd_en_in,
  input wire logic [7:0]  rdata_out,
  input wire logic [6:0]  port7_pin_out,
  input wire logic [6:0]  port7_pin_oe_out
);
  logic [7:0]  sel;
  logic [15:0] hcnt;
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Mirror of the select register and length of the tone high phase
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      sel <= 8'h00;
      hcnt <= 16'h0000;
    end else begin
      hcnt <= port7_pin_out[3] ? hcnt + 16'h0001 : 16'h0000;
      if (wr_en_in && addr_in == 16'hFF40 && bit_wr_in)
        sel[bit_sel_in] <= wdata_in[0];
      else if (wr_en_in && addr_in == 16'hFF40)
        sel <= wdata_in;
    end
  end
  sequence low_start;
    !port7_pin_out[2] [*2];
  endsequence
  sequence high_full;
    port7_pin_out[2] [*8] ##1 port7_pin_out[2] [*8] ##1 !port7_pin_out[2];
  endsequence
  AST_RESET_OUT: assert property (
    $rose(rstn_in) |-> rdata_out == 8'h00 && port7_pin_oe_out == 7'h00)
    else $error("outputs not cleared");
  AST_DIR_TOP: assert property (
    rd_en_in && addr_in == 16'hFF27 |=> rdata_out[7])
    else $error("direction bit 7 not one");
  AST_DIR_OE: assert property (
    rd_en_in && addr_in == 16'hFF27 && !wr_en_in
    |=> rdata_out[6:0] == ~port7_pin_oe_out)
    else $error("enable differs from direction");
  AST_TONE_LOW: assert property (
    !sel[7] && !$past(sel[7]) && !port7_pin_out[3] |=> !port7_pin_out[3])
    else $error("tone pin rose while off");
  AST_CLK_LOW: assert property (
    !sel[4] && !$past(sel[4]) && !port7_pin_out[2] |=> !port7_pin_out[2])
    else $error("clock pin rose while off");
  AST_CLK_START: assert property (
    $rose(sel[4]) && sel[3:0] != 4'h0 && sel[3:0] < 4'h8 |-> low_start)
    else $error("clock did not start low");
  AST_CLK_HIGH: assert property (
    $rose(port7_pin_out[2]) && sel[3:0] == 4'h4 |-> high_full)
    else $error("clock high phase wrong");
  AST_CLK_STOP: assert property (
    $fell(sel[4]) |-> ##[1:140] !port7_pin_out[2] [*8])
    else $error("clock did not stop");
  AST_TONE_HALF: assert property (
    $fell(port7_pin_out[3]) |-> hcnt == (16'h0400 << sel[6:5]))
    else $error("tone high phase wrong");
endmodule // clkbz_properties
`default_nettype wire

/* File: tb/clkbz_load.sv */
// Load on the clock and tone pins that counts cycles with a driven rising edge on either pin
`timescale 1ns/1ps
`default_nettype none
module clkbz_load (
  input  wire logic [0:0]  clk_in,
  input  wire logic [6:0]  pin_in,
  input  wire logic [6:0]  oe_in,
  output var  logic [15:0] rise_out
);
  logic [1:0] last = 2'b00;
  initial rise_out = 16'h0000;
  always @(posedge clk_in) begin
    last <= pin_in[3:2] & oe_in[3:2];
    if (|(pin_in[3:2] & oe_in[3:2] & ~last))
      rise_out <= rise_out + 16'h0001;
  end
endmodule // clkbz_load
`default_nettype wire

/* File: tb/tb.sv */
// Register and pin scenarios for the clock and tone outputs
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LIM = 20000;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic        wr_en_in = 1'b0;
  logic        bit_wr_in = 1'b0;
  logic [2:0]  bit_sel_in = 3'h0;
  logic [7:0]  wdata_in = 8'h00;
  logic        rd_en_in = 1'b0;
  logic        sub_clk_in = 1'b0;
  logic [6:0]  port7_latch_in = 7'h63;
  wire  [7:0]  rdata_out;
  wire  [6:0]  port7_pin_out;
  wire  [6:0]  port7_pin_oe_out;
  wire  [15:0] rises;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          n;
  int          k;
  always #2.5 clk_in = ~clk_in;
  always #100 sub_clk_in = ~sub_clk_in;
  clkbz_top #(.PRS_HALF(1)) u_clkbz_top (.clk_in, .rstn_in, .addr_in,
    .wr_en_in, .bit_wr_in, .bit_sel_in, .wdata_in, .rd_en_in, .sub_clk_in,
    .port7_latch_in, .rdata_out, .port7_pin_out, .port7_pin_oe_out);
  clkbz_load u_clkbz_load (.clk_in, .pin_in(port7_pin_out),
    .oe_in(port7_pin_oe_out), .rise_out(rises));
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic b, input logic [2:0] s,
                    input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    bit_wr_in <= b;
    bit_sel_in <= s;
    wdata_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    @(posedge clk_in);
    #1 chk(rdata_out, exp);
  endtask
  // Counts cycles until the pin shows the given level
  task automatic wt(input int b, input logic v);
    n = 0;
    while (port7_pin_out[b] !== v) begin
      @(posedge clk_in);
      #1 n++;
      if (n > LIM) begin
        n_fail++;
        wrap_up;
      end
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(16'hFF40, 8'h00);
    rd(16'hFF27, 8'hFF);
    wr(16'hFF27, 1'b0, 3'h0, 8'h00);
    rd(16'hFF27, 8'h80);
    chk(port7_pin_oe_out, 16'h007F);
    chk(port7_pin_out, 16'h0063);
    // Codes 0..3 would break the pin limit at this peripheral rate
    for (k = 4; k < 8; k++) begin
      wr(16'hFF40, 1'b0, 3'h0, 8'(k));
      wr(16'hFF40, 1'b1, 3'h4, 8'h01);
      wt(2, 1'b1);
      wt(2, 1'b0);
      chk(n[15:0], 16'h0001 << k);
      wr(16'hFF40, 1'b1, 3'h4, 8'h00);
      repeat (300) @(posedge clk_in);
      #1 chk(port7_pin_out[2], 16'h0000);
    end
    rd(16'hFF40, 8'h07);
    wr(16'hFF40, 1'b0, 3'h0, 8'h08);
    wr(16'hFF40, 1'b1, 3'h4, 8'h01);
    wt(2, 1'b1);
    wt(2, 1'b0);
    chk(n > 18 && n < 22, 16'h0001);
    wr(16'hFF40, 1'b1, 3'h4, 8'h00);
    repeat (300) @(posedge clk_in);
    wr(16'hFF40, 1'b0, 3'h0, 8'h09);
    wr(16'hFF40, 1'b1, 3'h4, 8'h01);
    #1 k = rises;
    repeat (1100) @(posedge clk_in);
    #1 chk(rises, k[15:0]);
    wr(16'hFF40, 1'b1, 3'h4, 8'h00);
    wr(16'hFF40, 1'b0, 3'h0, 8'h04);
    wr(16'hFF40, 1'b1, 3'h4, 8'h01);
    wt(2, 1'b1);
    wr(16'hFF40, 1'b1, 3'h4, 8'h00);
    repeat (300) @(posedge clk_in);
    for (k = 0; k < 4; k++) begin
      wr(16'hFF40, 1'b0, 3'h0, 8'(k << 5));
      wr(16'hFF40, 1'b1, 3'h7, 8'h01);
      wt(3, 1'b1);
      wt(3, 1'b0);
      chk(n[15:0], 16'h0400 << k);
      wr(16'hFF40, 1'b1, 3'h7, 8'h00);
      repeat (50) @(posedge clk_in);
      #1 chk(port7_pin_out[3], 16'h0000);
    end
    wrap_up;
  end
endmodule // tb
bind clkbz_top clkbz_properties u_clkbz_properties (.clk_in, .rstn_in,
  .addr_in, .wr_en_in, .bit_wr_in, .bit_sel_in, .wdata_in, .rd_en_in,
  .rdata_out, .port7_pin_out, .port7_pin_oe_out);
`default_nettype wire
